// *** rtl/srh_pkg.sv ***
package srh_pkg;

    // system clock
    localparam int unsigned CLK_HZ              = 20_000_000;

    // register selectors on the command port
    localparam logic [2:0] REG_DEVICE           = 3'h0;
    localparam logic [2:0] REG_QUES             = 3'h1;
    localparam logic [2:0] REG_QUES_POWER       = 3'h2;
    localparam logic [2:0] REG_QUES_CAL         = 3'h3;
    localparam logic [2:0] REG_STD_EVENT        = 3'h4;
    localparam logic [2:0] REG_STD_ENABLE       = 3'h5;
    localparam logic [2:0] REG_PAR_POLL         = 3'h6;
    localparam logic [2:0] REG_STATUS_BYTE      = 3'h7;
    localparam int unsigned NUM_SCPI            = 4;

    // register parts of the layered registers
    localparam logic [2:0] PART_EVENT           = 3'h0;
    localparam logic [2:0] PART_COND            = 3'h1;
    localparam logic [2:0] PART_PTR             = 3'h2;
    localparam logic [2:0] PART_NTR             = 3'h3;
    localparam logic [2:0] PART_ENABLE          = 3'h4;

    // reset values of the writable parts
    localparam logic [15:0] PTR_RESET           = 16'hFFFF;
    localparam logic [15:0] NTR_RESET           = 16'h0000;
    localparam logic [15:0] ENABLE_RESET        = 16'h0000;
    localparam logic [7:0]  STD_ENABLE_RESET    = 8'h00;
    localparam logic [7:0]  PAR_POLL_RESET      = 8'h00;

    // device status bit positions
    localparam int unsigned DEV_STATIC_SUM      = 0;
    localparam int unsigned DEV_STATIC_NO_MEAS  = 1;
    localparam int unsigned DEV_STATIC_BAD_RES  = 2;
    localparam int unsigned DEV_STATIC_WARN     = 3;
    localparam int unsigned DEV_STATIC_CRIT     = 4;
    localparam int unsigned DEV_LEGACY_LOCK     = 7;
    localparam int unsigned DEV_REF_PLL_LOCK    = 8;

    // questionable status bit positions
    localparam int unsigned QUES_POWER_SUM      = 3;
    localparam int unsigned QUES_CAL_SUM        = 8;
    localparam int unsigned QUES_SELF_CHECK     = 9;
    localparam int unsigned QPOW_CORRUPT        = 1;
    localparam int unsigned QPOW_ZERO_STALE     = 5;
    localparam int unsigned QCAL_ZERO_FAIL      = 1;

    // standard event bit positions
    localparam int unsigned ESR_OP_COMPLETE     = 0;
    localparam int unsigned ESR_QUERY_ERR       = 2;
    localparam int unsigned ESR_DEVICE_ERR      = 3;
    localparam int unsigned ESR_EXEC_ERR        = 4;
    localparam int unsigned ESR_CMD_ERR         = 5;
    localparam int unsigned ESR_USER_REQ        = 6;
    localparam int unsigned ESR_POWER_ON        = 7;

    // status byte bit positions
    localparam int unsigned STB_DEVICE_SUM      = 1;
    localparam int unsigned STB_ERR_QUEUE       = 2;
    localparam int unsigned STB_QUES_SUM        = 3;
    localparam int unsigned STB_MSG_AVAIL       = 4;
    localparam int unsigned STB_STD_EVENT_SUM   = 5;
    localparam int unsigned STB_MASTER_SUM      = 6;
    localparam int unsigned STB_OPER_SUM        = 7;

    // error code ranges
    localparam logic signed [15:0] ERR_EXEC_LEGACY = -16'sd200;
    localparam logic signed [15:0] ERR_CMD_HI      = -16'sd100;
    localparam logic signed [15:0] ERR_EXEC_HI     = -16'sd200;
    localparam logic signed [15:0] ERR_DEV_HI      = -16'sd300;
    localparam logic signed [15:0] ERR_DEV_LO      = -16'sd399;

    // indicator flash timing, half periods
    localparam int unsigned FAST_FLASH_HALF_MS  = 125;
    localparam int unsigned FAST_FLASH_CYCLES   = (CLK_HZ / 1000) * FAST_FLASH_HALF_MS;
    localparam logic [1:0]  SLOW_PER_FAST       = 2'h3;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  sel;
        logic [2:0]  part;
        logic [15:0] data;
    } srh_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } srh_resp_t;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] code;
    } srh_err_t;

    typedef enum logic [2:0] {
        SRH_LED_OFF  = 3'b001,
        SRH_LED_SLOW = 3'b010,
        SRH_LED_FAST = 3'b100
    } srh_led_mode_t;

endpackage

// *** rtl/srh_status_reporting_hierarchy.sv ***
`timescale 1ns/1ps

module srh_status_reporting_hierarchy #(
    parameter int unsigned FAST_HALF_CYCLES = srh_pkg::FAST_FLASH_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire srh_pkg::srh_cmd_t  cmd,
    output srh_pkg::srh_resp_t      resp,
    input  wire logic [3:0]       static_error,
    input  wire logic             ref_external,
    input  wire logic             ref_pll_locked,
    input  wire logic             power_up_self_check_fail,
    input  wire logic             power_data_corrupt,
    input  wire logic             zero_stale,
    input  wire logic             zero_failed,
    input  wire logic             legacy_set_cmd,
    input  wire logic             legacy_closed,
    input  wire logic             other_set_cmd,
    output logic                  other_set_accept,
    input  wire logic             opc_received,
    input  wire logic             commands_idle,
    input  wire logic             query_error,
    input  wire logic             user_request,
    input  wire srh_pkg::srh_err_t  err_in,
    output logic                  err_in_ready,
    output srh_pkg::srh_err_t       err_push,
    input  wire logic             error_queue_not_empty,
    input  wire logic             message_available,
    input  wire logic             master_summary,
    input  wire logic             operation_summary,
    output logic [7:0]            status_byte,
    output logic                  ist_flag,
    output logic                  led_red
);

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    logic        is_scpi;
    logic [1:0]  scpi_idx;
    logic        rd_cmd;
    logic        wr_cmd;

    assign is_scpi  = (cmd.sel < 3'(srh_pkg::NUM_SCPI));
    assign scpi_idx = cmd.sel[1:0];
    assign rd_cmd   = cmd.valid && !cmd.write;
    assign wr_cmd   = cmd.valid && cmd.write;

    ////////////////////////////////////////////////////////////////////////////
    // legacy channel lock

    logic lock_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            lock_q <= 1'b0;
        end else if (legacy_set_cmd) begin
            lock_q <= 1'b1;
        end else if (legacy_closed) begin
            lock_q <= 1'b0;
        end
    end

    // a legacy command arriving this cycle already locks out the others
    assign other_set_accept = !(lock_q || legacy_set_cmd);

    logic reject;
    assign reject = other_set_cmd && !other_set_accept;

    ////////////////////////////////////////////////////////////////////////////
    // error classification and queue push

    logic        err_take;
    logic        cls_cmd;
    logic        cls_exec;
    logic        cls_dev;

    // the lock rejection owns the queue port for its cycle; the source waits
    assign err_in_ready = !reject;
    assign err_take     = err_in.valid && err_in_ready;
    assign cls_cmd      = err_take && err_in.code <= srh_pkg::ERR_CMD_HI
                          && err_in.code > srh_pkg::ERR_EXEC_HI;
    assign cls_exec     = err_take && err_in.code <= srh_pkg::ERR_EXEC_HI
                          && err_in.code > srh_pkg::ERR_DEV_HI;
    assign cls_dev      = err_take && ((err_in.code <= srh_pkg::ERR_DEV_HI
                          && err_in.code >= srh_pkg::ERR_DEV_LO) || err_in.code > 16'sd0);

    always_ff @(posedge clk) begin
        if (reset) begin
            err_push <= '0;
        end else if (reject) begin
            err_push <= '{valid: 1'b1, code: srh_pkg::ERR_EXEC_LEGACY};
        end else if (cls_cmd || cls_exec || cls_dev) begin
            err_push <= '{valid: 1'b1, code: err_in.code};
        end else begin
            err_push <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition parts of the layered registers

    logic [15:0] cond     [srh_pkg::NUM_SCPI];
    logic [15:0] summary_vec;
    logic [15:0] dev_cond;
    logic [15:0] ques_cond;
    logic [15:0] qpow_cond;
    logic [15:0] qcal_cond;

    always_comb begin
        dev_cond = 16'h0000;
        dev_cond[srh_pkg::DEV_STATIC_NO_MEAS] = static_error[0];
        dev_cond[srh_pkg::DEV_STATIC_BAD_RES] = static_error[1];
        dev_cond[srh_pkg::DEV_STATIC_WARN]    = static_error[2];
        dev_cond[srh_pkg::DEV_STATIC_CRIT]    = static_error[3];
        dev_cond[srh_pkg::DEV_STATIC_SUM]     = |static_error;
        dev_cond[srh_pkg::DEV_LEGACY_LOCK]    = lock_q;
        dev_cond[srh_pkg::DEV_REF_PLL_LOCK]   = !ref_external || ref_pll_locked;

        qpow_cond = 16'h0000;
        qpow_cond[srh_pkg::QPOW_CORRUPT]    = power_data_corrupt;
        qpow_cond[srh_pkg::QPOW_ZERO_STALE] = zero_stale;

        qcal_cond = 16'h0000;
        qcal_cond[srh_pkg::QCAL_ZERO_FAIL] = zero_failed;

        ques_cond = 16'h0000;
        ques_cond[srh_pkg::QUES_POWER_SUM]  = summary_vec[srh_pkg::REG_QUES_POWER];
        ques_cond[srh_pkg::QUES_CAL_SUM]    = summary_vec[srh_pkg::REG_QUES_CAL];
        ques_cond[srh_pkg::QUES_SELF_CHECK] = power_up_self_check_fail;
    end

    assign cond[0] = dev_cond;
    assign cond[1] = ques_cond;
    assign cond[2] = qpow_cond;
    assign cond[3] = qcal_cond;

    ////////////////////////////////////////////////////////////////////////////
    // layered registers: filters, event, enable, summary

    logic [15:0] ptr_q    [srh_pkg::NUM_SCPI];
    logic [15:0] ntr_q    [srh_pkg::NUM_SCPI];
    logic [15:0] enable_q [srh_pkg::NUM_SCPI];
    logic [15:0] event_q  [srh_pkg::NUM_SCPI];
    logic [15:0] prev_q   [srh_pkg::NUM_SCPI];

    genvar gi;
    generate
        for (gi = 0; gi < srh_pkg::NUM_SCPI; gi++) begin : g_scpi
            logic hit;
            logic [15:0] rise;
            logic [15:0] fall;

            assign hit  = is_scpi && (scpi_idx == 2'(gi));
            assign rise = cond[gi] & ~prev_q[gi] & ptr_q[gi];
            assign fall = ~cond[gi] & prev_q[gi] & ntr_q[gi];

            always_ff @(posedge clk) begin
                if (reset) begin
                    ptr_q[gi]    <= srh_pkg::PTR_RESET;
                    ntr_q[gi]    <= srh_pkg::NTR_RESET;
                    enable_q[gi] <= srh_pkg::ENABLE_RESET;
                end else if (wr_cmd && hit) begin
                    // event and condition parts ignore writes
                    if (cmd.part == srh_pkg::PART_PTR) begin
                        ptr_q[gi] <= cmd.data;
                    end
                    if (cmd.part == srh_pkg::PART_NTR) begin
                        ntr_q[gi] <= cmd.data;
                    end
                    if (cmd.part == srh_pkg::PART_ENABLE) begin
                        enable_q[gi] <= cmd.data;
                    end
                end
            end

            // prev starts at zero so conditions true out of reset count as rising
            always_ff @(posedge clk) begin
                if (reset) begin
                    prev_q[gi] <= 16'h0000;
                end else begin
                    prev_q[gi] <= cond[gi];
                end
            end

            // a new edge in the cycle of the clearing read survives the read
            always_ff @(posedge clk) begin
                if (reset) begin
                    event_q[gi] <= 16'h0000;
                end else if (rd_cmd && hit && cmd.part == srh_pkg::PART_EVENT) begin
                    event_q[gi] <= rise | fall;
                end else begin
                    event_q[gi] <= event_q[gi] | rise | fall;
                end
            end

            assign summary_vec[gi] = |(event_q[gi] & enable_q[gi]);
        end
    endgenerate

    assign summary_vec[15:srh_pkg::NUM_SCPI] = '0;

    ////////////////////////////////////////////////////////////////////////////
    // standard event register and its enable

    logic [7:0] esr_q;
    logic [7:0] ese_q;
    logic [7:0] esr_set;
    logic       opc_pend_q;
    logic       power_on_q;
    logic       std_event_sum;

    always_ff @(posedge clk) begin
        if (reset) begin
            opc_pend_q <= 1'b0;
        end else if (opc_received) begin
            opc_pend_q <= 1'b1;
        end else if (commands_idle) begin
            opc_pend_q <= 1'b0;
        end
    end

    // power-on is reported once, on the first cycle after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            power_on_q <= 1'b1;
        end else begin
            power_on_q <= 1'b0;
        end
    end

    always_comb begin
        esr_set = 8'h00;
        esr_set[srh_pkg::ESR_OP_COMPLETE] = (opc_pend_q || opc_received) && commands_idle;
        esr_set[srh_pkg::ESR_QUERY_ERR]   = query_error;
        esr_set[srh_pkg::ESR_DEVICE_ERR]  = cls_dev;
        esr_set[srh_pkg::ESR_EXEC_ERR]    = cls_exec || reject;
        esr_set[srh_pkg::ESR_CMD_ERR]     = cls_cmd;
        esr_set[srh_pkg::ESR_USER_REQ]    = user_request;
        esr_set[srh_pkg::ESR_POWER_ON]    = power_on_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            esr_q <= 8'h00;
        end else if (rd_cmd && cmd.sel == srh_pkg::REG_STD_EVENT) begin
            esr_q <= esr_set;
        end else begin
            esr_q <= esr_q | esr_set;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ese_q <= srh_pkg::STD_ENABLE_RESET;
        end else if (wr_cmd && cmd.sel == srh_pkg::REG_STD_ENABLE) begin
            ese_q <= cmd.data[7:0];
        end
    end

    assign std_event_sum = |(esr_q & ese_q);

    ////////////////////////////////////////////////////////////////////////////
    // status byte and parallel poll

    logic [7:0] ppe_q;
    logic [7:0] stb;

    always_ff @(posedge clk) begin
        if (reset) begin
            ppe_q <= srh_pkg::PAR_POLL_RESET;
        end else if (wr_cmd && cmd.sel == srh_pkg::REG_PAR_POLL) begin
            ppe_q <= cmd.data[7:0];
        end
    end

    always_comb begin
        stb = 8'h00;
        stb[srh_pkg::STB_DEVICE_SUM]    = summary_vec[srh_pkg::REG_DEVICE];
        stb[srh_pkg::STB_ERR_QUEUE]     = error_queue_not_empty;
        stb[srh_pkg::STB_QUES_SUM]      = summary_vec[srh_pkg::REG_QUES];
        stb[srh_pkg::STB_MSG_AVAIL]     = message_available;
        stb[srh_pkg::STB_STD_EVENT_SUM] = std_event_sum;
        stb[srh_pkg::STB_MASTER_SUM]    = master_summary;
        stb[srh_pkg::STB_OPER_SUM]      = operation_summary;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_byte <= 8'h00;
            ist_flag    <= 1'b0;
        end else begin
            status_byte <= stb;
            ist_flag    <= |(stb & ppe_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [15:0] rd_data;

    always_comb begin
        rd_data = 16'h0000;
        if (is_scpi) begin
            unique case (cmd.part)
                srh_pkg::PART_EVENT:  rd_data = event_q[scpi_idx];
                srh_pkg::PART_COND:   rd_data = cond[scpi_idx];
                srh_pkg::PART_PTR:    rd_data = ptr_q[scpi_idx];
                srh_pkg::PART_NTR:    rd_data = ntr_q[scpi_idx];
                srh_pkg::PART_ENABLE: rd_data = enable_q[scpi_idx];
                default:              rd_data = 16'h0000;
            endcase
        end else begin
            unique case (cmd.sel)
                srh_pkg::REG_STD_EVENT:   rd_data = {8'h00, esr_q};
                srh_pkg::REG_STD_ENABLE:  rd_data = {8'h00, ese_q};
                srh_pkg::REG_PAR_POLL:    rd_data = {8'h00, ppe_q};
                srh_pkg::REG_STATUS_BYTE: rd_data = {8'h00, stb};
                default:                  rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            resp <= '0;
        end else begin
            resp.valid <= rd_cmd;
            resp.data  <= rd_cmd ? rd_data : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // red indicator flash

    srh_pkg::srh_led_mode_t led_mode;
    logic [23:0] flash_cnt_q;
    logic        fast_tick;
    logic [1:0]  slow_div_q;
    logic        fast_ph_q;
    logic        slow_ph_q;

    // critical outranks warning
    always_comb begin
        if (static_error[3]) begin
            led_mode = srh_pkg::SRH_LED_FAST;
        end else if (static_error[2]) begin
            led_mode = srh_pkg::SRH_LED_SLOW;
        end else begin
            led_mode = srh_pkg::SRH_LED_OFF;
        end
    end

    assign fast_tick = (flash_cnt_q == 24'(FAST_HALF_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (reset || fast_tick) begin
            flash_cnt_q <= 24'h000000;
        end else begin
            flash_cnt_q <= flash_cnt_q + 24'h000001;
        end
    end

    // slow phase toggles once per four fast half periods
    always_ff @(posedge clk) begin
        if (reset) begin
            slow_div_q <= 2'h0;
            fast_ph_q  <= 1'b0;
            slow_ph_q  <= 1'b0;
        end else if (fast_tick) begin
            fast_ph_q  <= !fast_ph_q;
            slow_div_q <= slow_div_q + 2'h1;
            if (slow_div_q == srh_pkg::SLOW_PER_FAST) begin
                slow_ph_q <= !slow_ph_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            led_red <= 1'b0;
        end else begin
            unique case (led_mode)
                srh_pkg::SRH_LED_FAST: led_red <= fast_ph_q;
                srh_pkg::SRH_LED_SLOW: led_red <= slow_ph_q;
                srh_pkg::SRH_LED_OFF:  led_red <= 1'b0;
            endcase
        end
    end

endmodule

// *** tb/srh_asserts.sv ***
`timescale 1ns/1ps
module srh_checker #(
    parameter int unsigned FAST_HALF_CYCLES = 4
) (
    input wire logic               clk,
    input wire logic               reset,
    input wire srh_pkg::srh_cmd_t  cmd,
    input wire srh_pkg::srh_resp_t resp,
    input wire logic [3:0]         static_error,
    input wire logic               legacy_set_cmd,
    input wire logic               other_set_cmd,
    input wire logic               other_set_accept,
    input wire srh_pkg::srh_err_t  err_in,
    input wire logic               err_in_ready,
    input wire srh_pkg::srh_err_t  err_push,
    input wire logic               led_red
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic rd   = cmd.valid && !cmd.write;
    wire logic rej  = other_set_cmd && !other_set_accept;
    wire logic take = err_in.valid && err_in_ready;
    wire logic cls  = err_in.code > 16'sh0000 || (err_in.code <= 16'shFF9C && err_in.code >= 16'shFE71);
    a_read_gets_answer: assert property (rd |=> resp.valid)
        else $error("read without answer");
    a_no_stray_answer: assert property (!rd |=> !resp.valid)
        else $error("answer without read");
    a_legacy_blocks_set: assert property (legacy_set_cmd |-> !other_set_accept)
        else $error("setting still accepted");
    a_reject_queues_code: assert property (rej |=> err_push.valid && err_push.code == 16'hFF38)
        else $error("rejection not queued");
    a_reject_stalls_err: assert property (err_in_ready == !rej)
        else $error("error input ready wrong");
    a_err_code_pushed: assert property (take && cls |=> err_push.valid && err_push.code == $past(err_in.code))
        else $error("error code not queued");
    a_bad_code_dropped: assert property (!(take && cls) && !rej |=> !err_push.valid)
        else $error("stray error queued");
    a_led_dark_no_err: assert property ((static_error[3:2] == 2'h0) [*2] |-> !led_red)
        else $error("indicator lit without error");
    c_read: cover property (rd ##1 resp.valid);
    c_reject: cover property (rej);
    c_err: cover property (take && cls);
endmodule
bind srh_status_reporting_hierarchy srh_checker #(.FAST_HALF_CYCLES(FAST_HALF_CYCLES)) i_chk (.clk, .reset, .cmd,
    .resp, .static_error, .legacy_set_cmd, .other_set_cmd, .other_set_accept, .err_in, .err_in_ready, .err_push,
    .led_red);

// *** tb/srh_host.sv ***
`timescale 1ns/1ps
module srh_host (
    input  wire logic               clk,
    input  wire srh_pkg::srh_resp_t resp,
    output srh_pkg::srh_cmd_t       cmd,
    output logic                    legacy_closed
);
    initial begin
        cmd = '0;
        legacy_closed = 1'b0;
    end
    // one request at a time; a missing answer reads back as DEAD
    task automatic acc(input logic w, input logic [2:0] s, input logic [2:0] p, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk);
        cmd <= '{1'b1, w, s, p, d};
        @(posedge clk);
        cmd <= '0;
        #1 q = resp.valid ? resp.data : 16'hDEAD;
    endtask
    task automatic close_legacy();
        @(posedge clk);
        legacy_closed <= 1'b1;
        @(posedge clk);
        legacy_closed <= 1'b0;
    endtask
endmodule

// *** tb/status_reporting_hierarchy_tb.sv ***
`timescale 1ns/1ps
module status_reporting_hierarchy_tb;
    logic clk, reset, ref_external, ref_pll_locked, power_up_self_check_fail, power_data_corrupt, zero_stale;
    logic zero_failed, legacy_set_cmd, legacy_closed, other_set_cmd, other_set_accept, opc_received;
    logic commands_idle, query_error, user_request, err_in_ready, error_queue_not_empty, message_available;
    logic master_summary, operation_summary, ist_flag, led_red;
    logic [3:0] static_error;
    logic [7:0] status_byte;
    logic [15:0] q;
    srh_pkg::srh_cmd_t cmd;
    srh_pkg::srh_resp_t resp;
    srh_pkg::srh_err_t err_in, err_push;
    int num_errors = 0, tests_run = 0, cycles = 0;
    logic [15:0] codes[9] = '{16'hFF9C, 16'hFF39, 16'hFF38, 16'hFED4, 16'hFE71, 16'h0005, 16'hFE70, 16'hFF9D, 16'h0000};
    logic [7:0] exps[9] = '{8'h20, 8'h20, 8'h10, 8'h08, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00};
    srh_status_reporting_hierarchy #(.FAST_HALF_CYCLES(4)) i_dut (.clk, .reset, .cmd, .resp, .static_error,
        .ref_external, .ref_pll_locked, .power_up_self_check_fail, .power_data_corrupt, .zero_stale, .zero_failed,
        .legacy_set_cmd, .legacy_closed, .other_set_cmd, .other_set_accept, .opc_received, .commands_idle,
        .query_error, .user_request, .err_in, .err_in_ready, .err_push, .error_queue_not_empty, .message_available,
        .master_summary, .operation_summary, .status_byte, .ist_flag, .led_red);
    srh_host i_host (.clk, .resp, .cmd, .legacy_closed);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] dev_cond(logic [3:0] se, logic ext, logic pll, logic lk);
        return {7'h0, !ext || pll, lk, 2'h0, se, |se};
    endfunction
    task automatic rd(input logic [2:0] s, input logic [2:0] p, output logic [15:0] v);
        i_host.acc(1'b0, s, p, 16'h0000, v);
    endtask
    task automatic wr(input logic [2:0] s, input logic [2:0] p, input logic [15:0] d);
        logic [15:0] v;
        i_host.acc(1'b1, s, p, d, v);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // k: user request, query error, operation complete, error report
    task automatic esr_case(input logic [3:0] k, input logic [15:0] c, input logic [7:0] e);
        logic [15:0] v;
        step(1);
        {user_request, query_error, opc_received} <= k[3:1];
        err_in <= '{k[0], c};
        step(1);
        {user_request, query_error, opc_received} <= 3'h0;
        err_in <= '0;
        step(2);
        #1 chk(status_byte[5], |e);
        rd(srh_pkg::REG_STD_EVENT, 3'h0, v);
        chk(v, e);
    endtask
    // settle first so a toggle count never straddles a mode change
    task automatic led_count(input logic [3:0] se, input int n, input logic [15:0] e);
        int t;
        logic last;
        t = 0;
        step(1);
        static_error <= se;
        step(40);
        #1 last = led_red;
        repeat (n) begin
            @(posedge clk);
            #1 if (led_red !== last) t++;
            last = led_red;
        end
        chk(t[15:0], e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {static_error, ref_external, ref_pll_locked, power_up_self_check_fail, power_data_corrupt} = 8'h00;
        {zero_stale, zero_failed, legacy_set_cmd, other_set_cmd, opc_received, query_error} = 6'h00;
        {user_request, error_queue_not_empty, message_available, master_summary, operation_summary} = 5'h00;
        commands_idle = 1'b1;
        err_in = '0;
        q = $urandom(32'h12D9);
        step(4);
        reset <= 1'b0;
        rd(srh_pkg::REG_STD_EVENT, 3'h0, q);
        chk(q, 16'h0080);
        rd(srh_pkg::REG_STD_EVENT, 3'h0, q);
        chk(q, 16'h0000);
        wr(srh_pkg::REG_STD_ENABLE, 3'h0, 16'h00FF);
        rd(srh_pkg::REG_STD_ENABLE, 3'h0, q);
        chk(q, 16'h00FF);
        repeat (12) begin
            step(1);
            {static_error, ref_external, ref_pll_locked} <= 6'($urandom);
            step(2);
            rd(srh_pkg::REG_DEVICE, srh_pkg::PART_COND, q);
            chk(q, dev_cond(static_error, ref_external, ref_pll_locked, 1'b0));
        end
        step(1);
        static_error <= 4'h0;
        wr(srh_pkg::REG_DEVICE, srh_pkg::PART_PTR, 16'h0000);
        wr(srh_pkg::REG_DEVICE, srh_pkg::PART_NTR, 16'h0002);
        rd(srh_pkg::REG_DEVICE, srh_pkg::PART_EVENT, q);
        step(1);
        static_error <= 4'h1;
        step(3);
        rd(srh_pkg::REG_DEVICE, srh_pkg::PART_EVENT, q);
        chk(q, 16'h0000);
        step(1);
        static_error <= 4'h0;
        step(3);
        rd(srh_pkg::REG_DEVICE, srh_pkg::PART_EVENT, q);
        chk(q, 16'h0002);
        wr(srh_pkg::REG_QUES_POWER, srh_pkg::PART_ENABLE, 16'h0022);
        wr(srh_pkg::REG_QUES_CAL, srh_pkg::PART_ENABLE, 16'h0002);
        step(1);
        {power_up_self_check_fail, power_data_corrupt, zero_stale, zero_failed} <= 4'hF;
        step(3);
        rd(srh_pkg::REG_QUES, srh_pkg::PART_COND, q);
        chk(q, 16'h0308);
        rd(srh_pkg::REG_QUES_POWER, srh_pkg::PART_EVENT, q);
        chk(q, 16'h0022);
        rd(srh_pkg::REG_QUES_CAL, srh_pkg::PART_COND, q);
        chk(q, 16'h0002);
        wr(srh_pkg::REG_QUES, srh_pkg::PART_ENABLE, 16'h0200);
        step(2);
        #1 chk(status_byte[3], 1'b1);
        wr(srh_pkg::REG_PAR_POLL, 3'h0, 16'h0040);
        rd(srh_pkg::REG_PAR_POLL, 3'h0, q);
        chk(q, 16'h0040);
        step(1);
        master_summary <= 1'b1;
        step(3);
        #1 chk(ist_flag, 1'b1);
        step(1);
        {master_summary, error_queue_not_empty, message_available} <= 3'h3;
        step(3);
        #1 chk(ist_flag, 1'b0);
        step(1);
        legacy_set_cmd <= 1'b1;
        step(1);
        legacy_set_cmd <= 1'b0;
        rd(srh_pkg::REG_DEVICE, srh_pkg::PART_COND, q);
        chk(q[7], 1'b1);
        step(1);
        other_set_cmd <= 1'b1;
        step(1);
        other_set_cmd <= 1'b0;
        rd(srh_pkg::REG_STD_EVENT, 3'h0, q);
        chk(q, 16'h0010);
        i_host.close_legacy();
        rd(srh_pkg::REG_DEVICE, srh_pkg::PART_COND, q);
        chk({q[7], other_set_accept}, 16'h0001);
        foreach (codes[i]) esr_case(4'h1, codes[i], exps[i]);
        esr_case(4'h2, 16'h0000, 8'h01);
        esr_case(4'h4, 16'h0000, 8'h04);
        esr_case(4'h8, 16'h0000, 8'h40);
        led_count(4'h8, 40, 16'h000A);
        led_count(4'h4, 64, 16'h0004);
        led_count(4'hC, 40, 16'h000A);
        test_done();
    end
endmodule
